// >>> test/cache_line_fill_master_tb.sv
// Purpose: Self-checking bench for the cache line fill master.
// Assumes: Slave memory word equals its address xor a fixed pattern.
// Notes:   Two configurations with one lane of stimulus and checks per channel, plus one with both masters removed.
`timescale 1ns/1ps
module fill_lane #(
	parameter int          IS_INSTR = 1,
	parameter int          NWORDS   = 8,
	parameter int          BURST    = 1,
	parameter logic [13:0] EXP_CFG  = 14'h0000
) (
	input  wire logic                   ref_clk_in,
	input  wire logic                   sys_rst_in,
	input  wire logic                   go_in,
	input  wire fill_pkg::cfg_status_s  cfg_in,
	output fill_pkg::miss_s             miss_out,
	input  wire logic                   miss_ready_in,
	input  wire fill_pkg::bus_req_s     req_in,
	output fill_pkg::bus_rsp_s          rsp_out,
	input  wire logic                   fill_valid_in,
	input  wire fill_pkg::fill_word_s   word_in,
	output logic                        fill_ready_out,
	input  wire fill_pkg::line_done_s   done_in,
	output int                          err_out,
	output int                          chk_out,
	output logic                        fin_out
);
	import fill_pkg::*;

	fill_word_s           exp_word[$];
	logic [ADDR_BITS-1:0] exp_addr[$];
	logic [ADDR_BITS-1:0] exp_base[$];
	logic [ADDR_BITS-1:0] addr;
	logic [ADDR_BITS-1:0] base;
	bus_req_s             prev_req;
	logic                 prev_wait;
	int                   cyc = 0;
	int                   stall_end = 0;
	int                   occ;
	int                   beats;
	int                   s;
	int                   w;
	int                   t;

	fill_slave_model #(.STALL(1)) fill_slave_model_inst (
		.ref_clk_in (ref_clk_in),
		.sys_rst_in (sys_rst_in),
		.req_in     (req_in),
		.rsp_out    (rsp_out)
	);

	task automatic cmp_val(input string what, input logic [39:0] exp, input logic [39:0] got);
		chk_out++;
		if (got !== exp) begin
			err_out++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// ***********************************
	// Miss driver
	// ***********************************
	initial begin
		miss_out = '0;
		fill_ready_out = 1'b0;
		fin_out = 1'b0;
		err_out = 0;
		chk_out = 0;
		wait (go_in);
		if (!IS_INSTR) cmp_val("config status", EXP_CFG, cfg_in);
		for (int i = 0; i < 24; i++) begin
			@(posedge ref_clk_in);
			addr = ($urandom() & ~ADDR_BITS'(NWORDS * 4 - 1)) | ADDR_BITS'((i % NWORDS) * 4 + $urandom_range(3));
			if (i == 10) stall_end = cyc + 80;
			miss_out <= {1'b1, addr};
			t = 0;
			do begin
				@(posedge ref_clk_in);
				t++;
			end while (miss_ready_in !== 1'b1 && t < 400);
			if (t >= 400) cmp_val("miss taken", 1, 0);
			miss_out <= '0;
		end
		t = 0;
		while (exp_word.size() > 0 && t < 2000) begin
			@(posedge ref_clk_in);
			t++;
		end
		cmp_val("words left", 0, exp_word.size());
		fin_out = 1'b1;
	end

	// Consumer with random and long stalls
	always @(posedge ref_clk_in) begin
		cyc <= cyc + 1;
		fill_ready_out <= (cyc >= stall_end) && ($urandom_range(3) != 0);
	end

	// ***********************************
	// Reference model and comparisons
	// ***********************************
	always @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			occ = 0;
			beats = 0;
			prev_wait = 1'b0;
		end else begin
			if (miss_ready_in === 1'b1) cmp_val("room for line", 1, 40'(occ + NWORDS <= FIFO_DEPTH));
			if (miss_out.valid && miss_ready_in === 1'b1) begin
				base = miss_out.addr & ~ADDR_BITS'(NWORDS * 4 - 1);
				s = IS_INSTR ? int'(miss_out.addr[4:2]) % NWORDS : 0;
				for (int k = 0; k < NWORDS; k++) begin
					w = (s + k) % NWORDS;
					exp_word.push_back({3'(w), 1'(k == NWORDS - 1), (base + 32'(w * 4)) ^ 32'h5A3C_0000});
					if (BURST == 0) exp_addr.push_back(base + 32'(w * 4));
				end
				if (BURST != 0) exp_addr.push_back(IS_INSTR ? {miss_out.addr[31:2], 2'b00} : base);
				exp_base.push_back(base);
			end
			if (prev_wait) cmp_val("held request", prev_req, req_in);
			if (req_in.read && !rsp_out.waitrequest) begin
				cmp_val("request address", exp_addr.pop_front(), req_in.address);
				if (BURST != 0) cmp_val("burst count", NWORDS, req_in.burstcount);
			end
			if (rsp_out.readdatavalid) begin
				beats++;
				occ++;
			end
			if (fill_valid_in && fill_ready_out) begin
				cmp_val("fill word", exp_word.pop_front(), word_in);
				occ--;
			end
			if (done_in.valid) begin
				cmp_val("line base", exp_base.pop_front(), done_in.base);
				cmp_val("beats before done", NWORDS, beats);
				beats = 0;
			end
			prev_req = req_in;
			prev_wait = req_in.read && rsp_out.waitrequest;
		end
	end
endmodule

module cache_line_fill_master_tb;
	import fill_pkg::*;

	logic       ref_clk_in;
	logic       sys_rst_in;
	logic       go;
	int         errs [4];
	int         chks [4];
	logic [3:0] fins;
	int         miscompares = 0;
	int         checks = 0;

	// ***********************************
	// Two configurations under test
	// ***********************************
	for (genvar g = 0; g < 2; g++) begin : cfg_g
		miss_s      [NUM_CH-1:0] miss;
		logic       [NUM_CH-1:0] miss_ready;
		bus_req_s   [NUM_CH-1:0] req;
		bus_rsp_s   [NUM_CH-1:0] rsp;
		logic       [NUM_CH-1:0] fvalid;
		fill_word_s [NUM_CH-1:0] fword;
		logic       [NUM_CH-1:0] fready;
		line_done_s [NUM_CH-1:0] done;
		cfg_status_s             cfg;

		cache_line_fill_master #(.IBURST_EN(g == 0 ? 1 : 0), .DLINE_BYTES(g == 0 ? 32 : 16)) cache_line_fill_master_inst (
			.ref_clk_in     (ref_clk_in),
			.sys_rst_in     (sys_rst_in),
			.miss_in        (miss),
			.miss_ready_out (miss_ready),
			.bus_req_out    (req),
			.bus_rsp_in     (rsp),
			.fill_valid_out (fvalid),
			.fill_word_out  (fword),
			.fill_ready_in  (fready),
			.line_done_out  (done),
			.cfg_status_out (cfg)
		);

		for (genvar c = 0; c < NUM_CH; c++) begin : ch_g
			fill_lane #(
				.IS_INSTR (c == CH_INSTR),
				.NWORDS   ((c == CH_INSTR || g == 0) ? 8 : 4),
				.BURST    (c == CH_DATA || g == 0),
				.EXP_CFG  ({4'hF, 1'(g == 0), 1'b1, 8'h00})
			) fill_lane_inst (
				.ref_clk_in     (ref_clk_in),
				.sys_rst_in     (sys_rst_in),
				.go_in          (go),
				.cfg_in         (cfg),
				.miss_out       (miss[c]),
				.miss_ready_in  (miss_ready[c]),
				.req_in         (req[c]),
				.rsp_out        (rsp[c]),
				.fill_valid_in  (fvalid[c]),
				.word_in        (fword[c]),
				.fill_ready_out (fready[c]),
				.done_in        (done[c]),
				.err_out        (errs[g * 2 + c]),
				.chk_out        (chks[g * 2 + c]),
				.fin_out        (fins[g * 2 + c])
			);
		end
	end

	// ***********************************
	// Both masters removed, TCM ports only
	// ***********************************
	miss_s       [NUM_CH-1:0] gone_miss;
	logic        [NUM_CH-1:0] gone_ready;
	bus_req_s    [NUM_CH-1:0] gone_req;
	cfg_status_s              gone_cfg;
	int                       gone_err = 0;
	int                       gone_chk = 0;

	cache_line_fill_master #(.ICACHE_BYTES(0), .DCACHE_BYTES(0), .DMASTER_OMIT(1), .ITCM_PORTS(0), .DTCM_PORTS(6))
	cache_line_fill_master_inst (
		.ref_clk_in     (ref_clk_in),
		.sys_rst_in     (sys_rst_in),
		.miss_in        (gone_miss),
		.miss_ready_out (gone_ready),
		.bus_req_out    (gone_req),
		.bus_rsp_in     ('0),
		.fill_valid_out (),
		.fill_word_out  (),
		.fill_ready_in  (2'b11),
		.line_done_out  (),
		.cfg_status_out (gone_cfg)
	);

	task automatic cmp_gone(input string what, input logic [13:0] exp, input logic [13:0] got);
		gone_chk++;
		if (got !== exp) begin
			gone_err++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// Misses offered all the time must never be taken
	always @(posedge ref_clk_in) begin
		gone_miss[CH_INSTR] <= {go, 32'($urandom())};
		gone_miss[CH_DATA]  <= {go, 32'($urandom())};
		if (go) begin
			cmp_gone("removed config", 14'h021F, gone_cfg);
			cmp_gone("removed ready", 14'h0000, 14'(gone_ready));
			cmp_gone("removed read", 14'h0000, 14'({gone_req[CH_DATA].read, gone_req[CH_INSTR].read}));
		end
	end

	task automatic give_verdict();
		for (int i = 0; i < 4; i++) begin
			miscompares += errs[i];
			checks += chks[i];
		end
		miscompares += gone_err;
		checks += gone_chk;
		if (miscompares == 0 && checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		ref_clk_in = 1'b0;
		forever #20 ref_clk_in = ~ref_clk_in;
	end

	// ***********************************
	// Main sequence and watchdog
	// ***********************************
	initial begin
		void'($urandom(32'h7A49));
		sys_rst_in = 1'b1;
		go = 1'b0;
		repeat (8) @(posedge ref_clk_in);
		sys_rst_in <= 1'b0;
		repeat (4) @(posedge ref_clk_in);
		go <= 1'b1;
		wait (&fins);
		give_verdict();
	end

	initial begin
		#(40 * 30000);
		miscompares++;
		give_verdict();
	end
endmodule

// >>> test/fill_slave_model.sv
// Purpose: Memory slave model for one fill master channel.
// Assumes: Requests hold while waitrequest is high; beats return in order.
// Notes:   Stalls and beat gaps are random when STALL is set.
`timescale 1ns/1ps
module fill_slave_model #(
	parameter int STALL = 1
) (
	input  wire logic                ref_clk_in,
	input  wire logic                sys_rst_in,
	input  wire fill_pkg::bus_req_s  req_in,
	output fill_pkg::bus_rsp_s       rsp_out
);
	import fill_pkg::*;

	logic [ADDR_BITS-1:0] beat_q[$];
	logic [ADDR_BITS-1:0] a;
	logic [ADDR_BITS-1:0] m;
	int                   n;

	initial rsp_out = '0;

	// ***********************************
	// Accept, then return beats
	// ***********************************
	always @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			beat_q.delete();
			rsp_out <= '0;
		end else begin
			if (req_in.read && !rsp_out.waitrequest) begin
				n = (req_in.burstcount == 0) ? 1 : int'(req_in.burstcount);
				m = ADDR_BITS'(n * WORD_BYTES - 1);
				for (int k = 0; k < n; k++) begin
					a = (req_in.address & ~m) | ((req_in.address + ADDR_BITS'(k * WORD_BYTES)) & m);
					beat_q.push_back(a);
				end
			end
			rsp_out.waitrequest <= (STALL != 0) && ($urandom_range(3) == 0);
			if (beat_q.size() > 0 && (STALL == 0 || $urandom_range(2) != 0)) begin
				a = beat_q.pop_front();
				rsp_out.readdatavalid <= 1'b1;
				rsp_out.readdata <= a ^ 32'h5A3C_0000;
			end else begin
				// Idle data line inverts every cycle, so it never repeats the previous cycle's value
				rsp_out.readdatavalid <= 1'b0;
				rsp_out.readdata <= ~rsp_out.readdata;
			end
		end
	end
endmodule

// >>> verilog/cache_line_fill_master.sv
// Purpose: Line fill engines for the instruction and data caches.
// Assumes: Bus slaves answer reads with readdatavalid, in request order.
// Notes:   A miss is taken only when the FIFO can hold the whole line.
`timescale 1ns/1ps
module cache_line_fill_master #(
	parameter int ICACHE_BYTES = fill_pkg::DEF_ICACHE_BYTES,
	parameter int DCACHE_BYTES = fill_pkg::DEF_DCACHE_BYTES,
	parameter int DLINE_BYTES  = fill_pkg::DEF_DLINE_BYTES,
	parameter int IBURST_EN    = fill_pkg::DEF_IBURST_EN,
	parameter int DBURST_EN    = fill_pkg::DEF_DBURST_EN,
	parameter int DMASTER_OMIT = fill_pkg::DEF_DMASTER_OMIT,
	parameter int ITCM_PORTS   = fill_pkg::DEF_ITCM_PORTS,
	parameter int DTCM_PORTS   = fill_pkg::DEF_DTCM_PORTS
) (
	input  wire logic                                    ref_clk_in,
	input  wire logic                                    sys_rst_in,
	input  wire fill_pkg::miss_s      [fill_pkg::NUM_CH-1:0] miss_in,
	output logic                      [fill_pkg::NUM_CH-1:0] miss_ready_out,
	output fill_pkg::bus_req_s        [fill_pkg::NUM_CH-1:0] bus_req_out,
	input  wire fill_pkg::bus_rsp_s   [fill_pkg::NUM_CH-1:0] bus_rsp_in,
	output logic                      [fill_pkg::NUM_CH-1:0] fill_valid_out,
	output fill_pkg::fill_word_s      [fill_pkg::NUM_CH-1:0] fill_word_out,
	input  wire logic                 [fill_pkg::NUM_CH-1:0] fill_ready_in,
	output fill_pkg::line_done_s      [fill_pkg::NUM_CH-1:0] line_done_out,
	output fill_pkg::cfg_status_s                            cfg_status_out
);
	import fill_pkg::*;

	// ***********************************
	// Configuration legalisation
	// ***********************************
	function automatic int clamp_tcm(input int n, input bit need);
		int r;
		r = n;
		if (r > TCM_MAX) begin
			r = TCM_MAX;
		end
		if (r < 1) begin
			r = need ? 1 : 0;
		end
		return r;
	endfunction

	localparam bit I_SIZE_OK = (ICACHE_BYTES >= CACHE_MIN) && (ICACHE_BYTES <= CACHE_MAX) &&
		((ICACHE_BYTES & (ICACHE_BYTES - 1)) == 0);
	localparam bit D_SIZE_OK = (DCACHE_BYTES >= CACHE_MIN) && (DCACHE_BYTES <= CACHE_MAX) &&
		((DCACHE_BYTES & (DCACHE_BYTES - 1)) == 0);
	localparam int D_LINE    = (DLINE_BYTES == LINE_SMALL || DLINE_BYTES == LINE_MID) ? DLINE_BYTES : LINE_BIG;
	localparam bit I_MASTER  = I_SIZE_OK;
	localparam bit D_MASTER  = D_SIZE_OK || (DMASTER_OMIT == 0);
	localparam int I_TCM     = clamp_tcm(ITCM_PORTS, !I_MASTER);
	localparam int D_TCM     = clamp_tcm(DTCM_PORTS, !D_MASTER);
	localparam int I_WORDS   = ILINE_BYTES / WORD_BYTES;
	localparam int D_WORDS   = D_SIZE_OK ? D_LINE / WORD_BYTES : 1;
	localparam bit I_BURST   = (IBURST_EN != 0);
	localparam bit D_BURST   = (DBURST_EN != 0) && (D_WORDS > 1);
	localparam int I_BEATS   = I_BURST ? I_WORDS : 1;
	localparam int D_BEATS   = D_BURST ? D_WORDS : 1;
	localparam logic [3:0] I_TCM_MASK = 4'((1 << I_TCM) - 1);
	localparam logic [3:0] D_TCM_MASK = 4'((1 << D_TCM) - 1);

	// ***********************************
	// Configuration status
	// ***********************************
	cfg_status_s cfg_q;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			cfg_q <= '0;
		end else begin
			cfg_q.imaster <= I_MASTER;
			cfg_q.dmaster <= D_MASTER;
			cfg_q.icache  <= I_SIZE_OK;
			cfg_q.dcache  <= D_SIZE_OK;
			cfg_q.ibursts <= I_BURST;
			cfg_q.dbursts <= D_BURST;
			cfg_q.itcm    <= I_TCM_MASK;
			cfg_q.dtcm    <= D_TCM_MASK;
		end
	end

	assign cfg_status_out = cfg_q;

	// ***********************************
	// Fill engines, one per master
	// ***********************************
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
			localparam bit         IS_I    = (ch == CH_INSTR);
			localparam int         W       = IS_I ? I_WORDS : D_WORDS;
			localparam bit         BURST   = IS_I ? I_BURST : D_BURST;
			localparam bit         PRESENT = IS_I ? I_MASTER : D_MASTER;
			localparam logic [3:0] WN      = 4'(W);
			localparam logic [3:0] BEATS   = 4'(IS_I ? I_BEATS : D_BEATS);
			localparam logic [2:0] IMASK   = 3'(W - 1);
			localparam logic [ADDR_BITS-1:0] OFS_MASK = ADDR_BITS'(W * WORD_BYTES - 1);

			fill_state_e                state_q;
			bus_req_s                   req_q;
			line_done_s                 done_q;
			logic [ADDR_BITS-1:0]       base_q;
			logic [IDX_BITS-1:0]        next_q;
			logic [IDX_BITS-1:0]        recv_q;
			logic [CNT_BITS-1:0]        cnt_q;
			logic                       ready_q;
			logic                       take;
			logic                       accepted;
			logic                       beat;
			logic                       last_beat;
			logic                       push_ready;
			logic                       space_ok;
			logic [IDX_BITS-1:0]        start_idx;
			logic [ADDR_BITS-1:0]       miss_base;
			logic [FIFO_CNT_BITS-1:0]   fifo_cnt;
			fill_word_s                 push_word;

			assign take      = miss_in[ch].valid && ready_q;
			assign accepted  = (state_q == ST_ADDR) && !bus_rsp_in[ch].waitrequest;
			assign beat      = (state_q == ST_DATA) && bus_rsp_in[ch].readdatavalid;
			assign last_beat = beat && (cnt_q == WN - 4'h1);
			assign miss_base = miss_in[ch].addr & ~OFS_MASK;
			assign space_ok  = push_ready && ((5'(FIFO_DEPTH) - fifo_cnt) >= 5'(W));

			// Instruction fills start at the critical word, data at word 0
			assign start_idx = IS_I ? (miss_in[ch].addr[IDX_MSB:WORD_LSB] & IMASK) : '0;

			assign push_word.word = recv_q;
			assign push_word.last = (cnt_q == WN - 4'h1);
			assign push_word.data = bus_rsp_in[ch].readdata;

			// Sequencer
			always_ff @(posedge ref_clk_in) begin
				if (sys_rst_in) begin
					state_q <= ST_IDLE;
				end else begin
					unique case (state_q)
						ST_IDLE: begin
							if (take) begin
								state_q <= ST_ADDR;
							end
						end
						ST_ADDR: begin
							if (!bus_rsp_in[ch].waitrequest) begin
								state_q <= ST_DATA;
							end
						end
						ST_DATA: begin
							if (last_beat) begin
								state_q <= ST_IDLE;
							end else if (beat && !BURST) begin
								state_q <= ST_ADDR;
							end
						end
						default: begin
							state_q <= ST_IDLE;
						end
					endcase
				end
			end

			// Bus request, held until the slave accepts it
			always_ff @(posedge ref_clk_in) begin
				if (sys_rst_in) begin
					req_q <= '0;
				end else if (take) begin
					req_q.read       <= 1'b1;
					req_q.address    <= miss_base | ADDR_BITS'({start_idx, 2'b00});
					req_q.burstcount <= BEATS;
				end else if (accepted) begin
					req_q.read <= 1'b0;
				end else if (beat && !last_beat && !BURST) begin
					req_q.read       <= 1'b1;
					req_q.address    <= base_q | ADDR_BITS'({next_q, 2'b00});
					req_q.burstcount <= BEATS;
				end
			end

			// Word indices wrap inside the line
			always_ff @(posedge ref_clk_in) begin
				if (sys_rst_in) begin
					base_q <= '0;
					next_q <= '0;
					recv_q <= '0;
					cnt_q  <= '0;
				end else if (take) begin
					base_q <= miss_base;
					next_q <= start_idx;
					recv_q <= start_idx;
					cnt_q  <= '0;
				end else begin
					if (accepted) begin
						next_q <= (next_q + 3'h1) & IMASK;
					end
					if (beat) begin
						recv_q <= (recv_q + 3'h1) & IMASK;
						cnt_q  <= cnt_q + 4'h1;
					end
				end
			end

			// Line complete only on its last word
			always_ff @(posedge ref_clk_in) begin
				if (sys_rst_in) begin
					done_q <= '0;
				end else begin
					done_q.valid <= last_beat;
					if (last_beat) begin
						done_q.base <= base_q;
					end
				end
			end

			// Take a miss only when the whole line fits
			always_ff @(posedge ref_clk_in) begin
				if (sys_rst_in) begin
					ready_q <= 1'b0;
				end else begin
					ready_q <= PRESENT && (state_q == ST_IDLE) && !take && space_ok;
				end
			end

			fill_fifo #(
				.WIDTH ($bits(fill_word_s)),
				.DEPTH (FIFO_DEPTH)
			) u_fifo (
				.ref_clk_in    (ref_clk_in),
				.sys_rst_in    (sys_rst_in),
				.in_valid_in   (beat),
				.in_data_in    (push_word),
				.in_ready_out  (push_ready),
				.out_valid_out (fill_valid_out[ch]),
				.out_data_out  (fill_word_out[ch]),
				.out_ready_in  (fill_ready_in[ch]),
				.count_out     (fifo_cnt)
			);

			assign bus_req_out[ch]    = req_q;
			assign miss_ready_out[ch] = ready_q;
			assign line_done_out[ch]  = done_q;
		end
	endgenerate

	// ***********************************
	// Checks
	// ***********************************
	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (sys_rst_in);

	localparam logic [3:0] I_BEATS_4 = 4'(I_BEATS);
	localparam logic [3:0] D_BEATS_4 = 4'(D_BEATS);
	localparam logic [ADDR_BITS-1:0] D_OFS = ADDR_BITS'(D_WORDS * WORD_BYTES - 1);

	logic [CNT_BITS-1:0] d_beats_q;

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in || line_done_out[CH_DATA].valid) begin
			d_beats_q <= '0;
		end else if (bus_rsp_in[CH_DATA].readdatavalid && !bus_req_out[CH_DATA].read &&
			!miss_ready_out[CH_DATA]) begin
			d_beats_q <= d_beats_q + 4'h1;
		end
	end

	sequence s_imiss_taken;
		miss_in[CH_INSTR].valid && miss_ready_out[CH_INSTR];
	endsequence

	sequence s_dmiss_taken;
		miss_in[CH_DATA].valid && miss_ready_out[CH_DATA];
	endsequence

	sequence s_stalled(int c);
		bus_req_out[c].read && bus_rsp_in[c].waitrequest;
	endsequence

	property p_icache_size;
		cfg_status_out.icache |-> (ICACHE_BYTES >= CACHE_MIN) && (ICACHE_BYTES <= CACHE_MAX);
	endproperty
	a_icache_size: assert property (p_icache_size) else $error("icache size out of range");

	property p_imaster_gone;
		!$past(sys_rst_in) && !cfg_status_out.imaster |-> !bus_req_out[CH_INSTR].read && cfg_status_out.itcm[0];
	endproperty
	a_imaster_gone: assert property (p_imaster_gone) else $error("instr master active without cache");

	property p_ifill_mode;
		bus_req_out[CH_INSTR].read |-> bus_req_out[CH_INSTR].burstcount == I_BEATS_4;
	endproperty
	a_ifill_mode: assert property (p_ifill_mode) else $error("instr burstcount wrong for mode");

	property p_icrit_first;
		s_imiss_taken |=> bus_req_out[CH_INSTR].read &&
			bus_req_out[CH_INSTR].address == ($past(miss_in[CH_INSTR].addr) & ~32'h0000_0003);
	endproperty
	a_icrit_first: assert property (p_icrit_first) else $error("instr fill not critical word first");

	property p_itcm_ports;
		(cfg_status_out.itcm & (cfg_status_out.itcm + 4'h1)) == 4'h0;
	endproperty
	a_itcm_ports: assert property (p_itcm_ports) else $error("instr tcm ports not contiguous");

	property p_dcache_size;
		cfg_status_out.dcache |-> (DCACHE_BYTES >= CACHE_MIN) && (DCACHE_BYTES <= CACHE_MAX);
	endproperty
	a_dcache_size: assert property (p_dcache_size) else $error("dcache size out of range");

	property p_dline_size;
		D_LINE == LINE_SMALL || D_LINE == LINE_MID || D_LINE == LINE_BIG;
	endproperty
	a_dline_size: assert property (p_dline_size) else $error("data line size illegal");

	property p_dmaster_gone;
		!$past(sys_rst_in) && !cfg_status_out.dmaster |-> !bus_req_out[CH_DATA].read && cfg_status_out.dtcm[0];
	endproperty
	a_dmaster_gone: assert property (p_dmaster_gone) else $error("data master active when omitted");

	property p_dburst_len;
		bus_req_out[CH_DATA].read |-> bus_req_out[CH_DATA].burstcount == D_BEATS_4;
	endproperty
	a_dburst_len: assert property (p_dburst_len) else $error("data burst length wrong");

	property p_dline_base;
		s_dmiss_taken |=> bus_req_out[CH_DATA].read &&
			bus_req_out[CH_DATA].address == ($past(miss_in[CH_DATA].addr) & ~D_OFS);
	endproperty
	a_dline_base: assert property (p_dline_base) else $error("data burst not line aligned");

	property p_dtcm_ports;
		(cfg_status_out.dtcm & (cfg_status_out.dtcm + 4'h1)) == 4'h0;
	endproperty
	a_dtcm_ports: assert property (p_dtcm_ports) else $error("data tcm ports not contiguous");

	property p_req_hold(int c);
		s_stalled(c) |=> $stable(bus_req_out[c]);
	endproperty
	a_ireq_hold: assert property (p_req_hold(CH_INSTR)) else $error("instr request dropped");
	a_dreq_hold: assert property (p_req_hold(CH_DATA)) else $error("data request dropped");

	property p_dline_whole;
		line_done_out[CH_DATA].valid |-> $past(d_beats_q) == D_BEATS_4 - 4'h1 || !D_BURST;
	endproperty
	a_dline_whole: assert property (p_dline_whole) else $error("data line done early");

endmodule

// >>> verilog/fill_fifo.sv
// Purpose: Flip-flop FIFO with valid and ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes:   Occupancy count is exported so the filler can reserve room.
`timescale 1ns/1ps
module fill_fifo #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 16
) (
	input  wire logic                         ref_clk_in,
	input  wire logic                         sys_rst_in,
	input  wire logic                         in_valid_in,
	input  wire logic [WIDTH-1:0]             in_data_in,
	output logic                              in_ready_out,
	output logic                              out_valid_out,
	output logic [WIDTH-1:0]                  out_data_out,
	input  wire logic                         out_ready_in,
	output logic [$clog2(DEPTH+1)-1:0]        count_out
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0]    wr_q;
	logic [PW-1:0]    rd_q;
	logic [CW-1:0]    cnt_q;
	logic             push;
	logic             pop;

	assign in_ready_out  = (cnt_q != CW'(DEPTH));
	assign out_valid_out = (cnt_q != '0);
	assign out_data_out  = mem_q[rd_q];
	assign count_out     = cnt_q;
	assign push          = in_valid_in && in_ready_out;
	assign pop           = out_valid_out && out_ready_in;

	always_ff @(posedge ref_clk_in) begin
		if (push) begin
			mem_q[wr_q] <= in_data_in;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (sys_rst_in) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
			cnt_q <= cnt_q + CW'(push) - CW'(pop);
		end
	end

endmodule

// >>> verilog/fill_pkg.sv
// Purpose: Shared constants and types for the cache line fill master.
// Assumes: One 25 MHz clock, synchronous active-high reset, 32-bit words.
// Notes:   Configuration choices are top-level parameters, legalised there.
// How it works
// - The instruction cache is 512 bytes to 64 KBytes in powers of two, or absent.
// - Without an instruction cache there is no instruction master and one instruction TCM port at least.
// - An option picks burst or single-word fills for instruction lines.
// - A fetch to the first word of an instruction line fills it at ascending word addresses.
// - A fetch to a later word fetches that word first, ascends to the line end, then wraps to the start.
// - One to four instruction TCM ports may be present, each for exactly one memory.
// - The data cache is 512 bytes to 64 KBytes in powers of two, or absent.
// - The data line is 4, 16 or 32 bytes long.
// - Without a data cache the data master may be removed, and then a data TCM port is present.
// - Data bursts are used only for lines above 4 bytes: 4 beats for 16 bytes, 8 beats for 32 bytes.
// - A data miss burst starts at the line base and ascends through every word.
// - One to four data TCM ports may be present, each for exactly one memory.
package fill_pkg;

	// ***********************************
	// Sizes and limits
	// ***********************************
	localparam int ADDR_BITS       = 32;
	localparam int WORD_BITS       = 32;
	localparam int WORD_BYTES      = 4;
	localparam int WORD_LSB        = 2;
	localparam int IDX_MSB         = 4;
	localparam int IDX_BITS        = 3;
	localparam int CNT_BITS        = 4;
	localparam int ILINE_BYTES     = 32;
	localparam int CACHE_MIN       = 512;
	localparam int CACHE_MAX       = 65536;
	localparam int LINE_SMALL      = 4;
	localparam int LINE_MID        = 16;
	localparam int LINE_BIG        = 32;
	localparam int TCM_MAX         = 4;
	localparam int FIFO_DEPTH      = 16;
	localparam int FIFO_CNT_BITS   = 5;
	localparam int NUM_CH          = 2;
	localparam int CH_INSTR        = 0;
	localparam int CH_DATA         = 1;

	// ***********************************
	// Default configuration
	// ***********************************
	localparam int DEF_ICACHE_BYTES = 4096;
	localparam int DEF_DCACHE_BYTES = 2048;
	localparam int DEF_DLINE_BYTES  = 32;
	localparam int DEF_IBURST_EN    = 1;
	localparam int DEF_DBURST_EN    = 1;
	localparam int DEF_DMASTER_OMIT = 0;
	localparam int DEF_ITCM_PORTS   = 0;
	localparam int DEF_DTCM_PORTS   = 0;

	// ***********************************
	// Types
	// ***********************************
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_DATA = 2'b10
	} fill_state_e;

	typedef struct packed {
		logic                 valid;
		logic [ADDR_BITS-1:0] addr;
	} miss_s;

	typedef struct packed {
		logic                 read;
		logic [ADDR_BITS-1:0] address;
		logic [CNT_BITS-1:0]  burstcount;
	} bus_req_s;

	typedef struct packed {
		logic                 waitrequest;
		logic                 readdatavalid;
		logic [WORD_BITS-1:0] readdata;
	} bus_rsp_s;

	typedef struct packed {
		logic [IDX_BITS-1:0]  word;
		logic                 last;
		logic [WORD_BITS-1:0] data;
	} fill_word_s;

	typedef struct packed {
		logic                 valid;
		logic [ADDR_BITS-1:0] base;
	} line_done_s;

	typedef struct packed {
		logic       imaster;
		logic       dmaster;
		logic       icache;
		logic       dcache;
		logic       ibursts;
		logic       dbursts;
		logic [3:0] itcm;
		logic [3:0] dtcm;
	} cfg_status_s;

endpackage
